// file: design/ext_pin_irq_unit.sv
// External pin and pin-change interrupt unit with AHB-Lite registers
//
// Operation
// - Unused bits of control, mask, flag and enable registers read zero.
// - Line 1 sense field: 00 low, 01 any change, 10 fall, 11 rise.
// - Line 0 sense field uses the same four encodings.
// - Line value is sampled before edges; pulses over one clock are caught.
// - A line requests only when global and its own enable are set.
// - Line enables sit at bit 1 for line 1, bit 0 for line 0.
// - Pin activity requests even when the pin is driven as an output.
// - Edge or change event sets the line's pending flag, bit 1 or 0.
// - A line flag clears when its vector is taken by the core.
// - Writing one clears a pending flag; writing zero leaves it.
// - A line in low-level mode always reads its flag as clear.
// - Group enables at bits 2,1,0, effective only with global enable.
// - Any change on an enabled pin in an enabled group requests.
// - Group change sets its flag; vector taken or write-one clears it.
// - Group 2 mask enables per pin, only with the group 2 enable.
// - Group 1 mask uses bits 6 to 0; bit 7 reads zero.
// - Each group has its own vector, apart from the line vectors.
// - Pin-change detection needs no clock edge to see a change.
// - Low-level sensing needs no clock edge; edges need the clock.
// - Level mode requests as long as the pin is low and enabled.
// - Group 0 mask has eight per-pin enables, gated by group 0 enable.
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/100ps
`include "ext_irq_defs.svh"
module ext_pin_irq_unit #(
   parameter int ADDR_W = 12
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic hsel_in,
   input wire logic [ADDR_W-1:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic global_irq_en_in,
   input wire ext_irq_pkg::vec_type vector_taken_in,
   input wire logic ext_line0_in,
   input wire logic ext_line1_in,
   input wire logic [7:0] group0_pins_in,
   input wire logic [6:0] group1_pins_in,
   input wire logic [7:0] group2_pins_in,
   output ext_irq_pkg::vec_type irq_request_out
);
   import ext_irq_pkg::*;

   // True when an address equals the register word address of an index
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0] idx);
      return a == ADDR_W'({idx, 2'b00});
   endfunction: hit

   logic [7:0] sense_ctrl_r;
   logic [7:0] sense_ctrl_nxt;
   logic [7:0] line_en_r;
   logic [7:0] line_en_nxt;
   logic [7:0] group_en_r;
   logic [7:0] group_en_nxt;
   logic [7:0] mask0_r;
   logic [7:0] mask0_nxt;
   logic [7:0] mask1_r;
   logic [7:0] mask1_nxt;
   logic [7:0] mask2_r;
   logic [7:0] mask2_nxt;
   logic [7:0] line_flag_r;
   logic [7:0] line_flag_nxt;
   logic [7:0] group_flag_r;
   logic [7:0] group_flag_nxt;
   vec_type req_r;
   vec_type req_nxt;
   logic [31:0] hrdata_r;
   logic hreadyout_r;
   logic hresp_r;
   logic dp_wr_r;
   logic [ADDR_W-1:0] dp_addr_r;
   logic accept;
   logic [7:0] wdata;
   logic [7:0] rd_nxt;
   logic [1:0] line_ev;
   logic [1:0] line_low;
   logic [1:0] level_mode;
   logic [2:0] grp_chg;
   logic [7:0] line_w1c;
   logic [7:0] group_w1c;
   sense_type sense0;
   sense_type sense1;

   // ---------------- AHB-Lite slave ----------------
   // Zero wait states; response is always OKAY
   assign accept = hsel_in & htrans_in[1] & hready_in;
   assign wdata = hwdata_in[7:0];

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         dp_wr_r <= 1'b0;
         dp_addr_r <= '0;
      end else begin
         dp_wr_r <= accept & hwrite_in;
         dp_addr_r <= haddr_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
      end else begin
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
      end
   end

   // Read data comes from next-state values so a read right behind
   // a write sees the written value
   always_comb begin
      rd_nxt = 8'h00;
      if (hit(haddr_in, `LINE_EN_IDX)) begin
         rd_nxt = line_en_nxt;
      end else if (hit(haddr_in, `LINE_FLAG_IDX)) begin
         rd_nxt = line_flag_nxt;
      end else if (hit(haddr_in, `GROUP_FLAG_IDX)) begin
         rd_nxt = group_flag_nxt;
      end else if (hit(haddr_in, `GROUP_EN_IDX)) begin
         rd_nxt = group_en_nxt;
      end else if (hit(haddr_in, `SENSE_CTRL_IDX)) begin
         rd_nxt = sense_ctrl_nxt;
      end else if (hit(haddr_in, `GROUP0_MASK_IDX)) begin
         rd_nxt = mask0_nxt;
      end else if (hit(haddr_in, `GROUP1_MASK_IDX)) begin
         rd_nxt = mask1_nxt;
      end else if (hit(haddr_in, `GROUP2_MASK_IDX)) begin
         rd_nxt = mask2_nxt;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         hrdata_r <= 32'h0000_0000;
      end else if (accept & ~hwrite_in) begin
         hrdata_r <= {24'h00_0000, rd_nxt};
      end
   end

   // ---------------- Control registers ----------------
   always_comb begin
      sense_ctrl_nxt = sense_ctrl_r;
      line_en_nxt = line_en_r;
      group_en_nxt = group_en_r;
      mask0_nxt = mask0_r;
      mask1_nxt = mask1_r;
      mask2_nxt = mask2_r;
      line_w1c = 8'h00;
      group_w1c = 8'h00;
      if (dp_wr_r) begin
         if (hit(dp_addr_r, `SENSE_CTRL_IDX)) begin
            sense_ctrl_nxt = wdata & `SENSE_CTRL_WMASK;
         end else if (hit(dp_addr_r, `LINE_EN_IDX)) begin
            line_en_nxt = wdata & `LINE_EN_WMASK;
         end else if (hit(dp_addr_r, `GROUP_EN_IDX)) begin
            group_en_nxt = wdata & `GROUP_EN_WMASK;
         end else if (hit(dp_addr_r, `GROUP0_MASK_IDX)) begin
            mask0_nxt = wdata & `GROUP0_MASK_WMASK;
         end else if (hit(dp_addr_r, `GROUP1_MASK_IDX)) begin
            mask1_nxt = wdata & `GROUP1_MASK_WMASK;
         end else if (hit(dp_addr_r, `GROUP2_MASK_IDX)) begin
            mask2_nxt = wdata & `GROUP2_MASK_WMASK;
         end else if (hit(dp_addr_r, `LINE_FLAG_IDX)) begin
            line_w1c = wdata & `LINE_FLAG_WMASK;
         end else if (hit(dp_addr_r, `GROUP_FLAG_IDX)) begin
            group_w1c = wdata & `GROUP_FLAG_WMASK;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         sense_ctrl_r <= `REG_RESET;
         line_en_r <= `REG_RESET;
         group_en_r <= `REG_RESET;
         mask0_r <= `REG_RESET;
         mask1_r <= `REG_RESET;
         mask2_r <= `REG_RESET;
      end else begin
         sense_ctrl_r <= sense_ctrl_nxt;
         line_en_r <= line_en_nxt;
         group_en_r <= group_en_nxt;
         mask0_r <= mask0_nxt;
         mask1_r <= mask1_nxt;
         mask2_r <= mask2_nxt;
      end
   end

   // ---------------- Detectors ----------------
   assign sense0 = sense_type'(sense_ctrl_r[`SENSE0_LSB +: 2]);
   assign sense1 = sense_type'(sense_ctrl_r[`SENSE1_LSB +: 2]);
   assign level_mode[0] = (sense0 == MODE_LOW);
   assign level_mode[1] = (sense1 == MODE_LOW);

   // Pins are read whatever their port direction, so software can
   // drive them to raise its own interrupt
   line_sense_detect u_line0 (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .pin_in(ext_line0_in),
      .sense_in(sense0),
      .event_out(line_ev[0]),
      .low_out(line_low[0])
   );

   line_sense_detect u_line1 (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .pin_in(ext_line1_in),
      .sense_in(sense1),
      .event_out(line_ev[1]),
      .low_out(line_low[1])
   );

   pin_change_group #(.WIDTH(8)) u_group0 (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .pins_in(group0_pins_in),
      .mask_in(mask0_r),
      .enable_in(group_en_r[0]),
      .change_out(grp_chg[0])
   );

   pin_change_group #(.WIDTH(7)) u_group1 (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .pins_in(group1_pins_in),
      .mask_in(mask1_r[6:0]),
      .enable_in(group_en_r[1]),
      .change_out(grp_chg[1])
   );

   pin_change_group #(.WIDTH(8)) u_group2 (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .pins_in(group2_pins_in),
      .mask_in(mask2_r),
      .enable_in(group_en_r[2]),
      .change_out(grp_chg[2])
   );

   // ---------------- Pending flags ----------------
   // A new event in the clearing cycle wins over the clear
   always_comb begin
      line_flag_nxt = 8'h00;
      group_flag_nxt = 8'h00;
      for (int i = 0; i < 2; i++) begin
         if (level_mode[i]) begin
            line_flag_nxt[i] = 1'b0;
         end else begin
            line_flag_nxt[i] = line_ev[i] |
               (line_flag_r[i] & ~line_w1c[i] &
                ~vector_taken_in[`VEC_LINE0 + i]);
         end
      end
      for (int g = 0; g < 3; g++) begin
         group_flag_nxt[g] = grp_chg[g] |
            (group_flag_r[g] & ~group_w1c[g] &
             ~vector_taken_in[`VEC_GROUP0 + g]);
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         line_flag_r <= `REG_RESET;
         group_flag_r <= `REG_RESET;
      end else begin
         line_flag_r <= line_flag_nxt;
         group_flag_r <= group_flag_nxt;
      end
   end

   // ---------------- Requests ----------------
   // One request line per vector; level requests follow the live pin
   always_comb begin
      req_nxt = '0;
      for (int i = 0; i < 2; i++) begin
         req_nxt[`VEC_LINE0 + i] = global_irq_en_in & line_en_r[i] &
            (level_mode[i] ? line_low[i] : line_flag_nxt[i]);
      end
      for (int g = 0; g < 3; g++) begin
         req_nxt[`VEC_GROUP0 + g] = global_irq_en_in &
            group_en_r[g] & group_flag_nxt[g];
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         req_r <= '0;
      end else begin
         req_r <= req_nxt;
      end
   end

   assign irq_request_out = req_r;
   assign hrdata_out = hrdata_r;
   assign hreadyout_out = hreadyout_r;
   assign hresp_out = hresp_r;

   // ---------------- Assertions ----------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);

   AST_SENSE_RESERVED: assert property (
      accept && !hwrite_in && hit(haddr_in, `SENSE_CTRL_IDX)
      |=> hrdata_out[31:4] == 28'h000_0000)
      else $error("sense control reserved bits read nonzero");

   AST_MASK1_BIT7: assert property (
      accept && !hwrite_in && hit(haddr_in, `GROUP1_MASK_IDX)
      |=> hrdata_out[7] == 1'b0)
      else $error("group 1 mask bit 7 read nonzero");

   AST_GLOBAL_GATE: assert property (
      !global_irq_en_in |=> irq_request_out == 5'h00)
      else $error("request raised with global enable low");

   AST_LEVEL_FLAG_CLEAR: assert property (
      level_mode[0] ##1 level_mode[0] |-> !line_flag_r[0])
      else $error("line 0 flag set in level mode");

   AST_EDGE_SETS_FLAG: assert property (
      line_ev[1] && !level_mode[1] |=> line_flag_r[1])
      else $error("line 1 event did not set its flag");

   AST_LEVEL_REQUEST: assert property (
      level_mode[0] && line_en_r[0] && global_irq_en_in
      && !ext_line0_in |=> irq_request_out[`VEC_LINE0])
      else $error("low level did not request");

   AST_W1C_CLEARS: assert property (
      dp_wr_r && hit(dp_addr_r, `GROUP_FLAG_IDX) && hwdata_in[1]
      && !grp_chg[1] |=> !group_flag_r[1])
      else $error("write one did not clear group 1 flag");

   AST_TAKEN_CLEARS: assert property (
      vector_taken_in[`VEC_LINE0] && !line_ev[0]
      && !(dp_wr_r && hit(dp_addr_r, `LINE_FLAG_IDX))
      |=> !line_flag_r[0] && !irq_request_out[`VEC_LINE0]
          || level_mode[0])
      else $error("vector taken did not clear line 0 flag");

   AST_GROUP_REQUEST: assert property (
      grp_chg[2] && group_en_r[2] && global_irq_en_in
      |=> group_flag_r[2] && irq_request_out[`VEC_GROUP2])
      else $error("group 2 change did not request");

   AST_RESET_CLEAN: assert property (
      @(posedge clk_in) disable iff (1'b0)
      !rst_b_in |=> irq_request_out == 5'h00
      && line_flag_r == 8'h00 && group_flag_r == 8'h00)
      else $error("pending state survived reset");
endmodule: ext_pin_irq_unit

// file: design/ext_irq_defs.svh
// Offsets, field positions, write masks and reset values of the unit
`ifndef EXT_IRQ_DEFS_SVH
`define EXT_IRQ_DEFS_SVH

// Register indices; byte address is four times the index
`define LINE_EN_IDX 8'h3D
`define LINE_FLAG_IDX 8'h3C
`define GROUP_FLAG_IDX 8'h3B
`define GROUP_EN_IDX 8'h68
`define SENSE_CTRL_IDX 8'h69
`define GROUP0_MASK_IDX 8'h6B
`define GROUP1_MASK_IDX 8'h6C
`define GROUP2_MASK_IDX 8'h6D

// Writable bits of each register
`define SENSE_CTRL_WMASK 8'h0F
`define LINE_EN_WMASK 8'h03
`define LINE_FLAG_WMASK 8'h03
`define GROUP_EN_WMASK 8'h07
`define GROUP_FLAG_WMASK 8'h07
`define GROUP0_MASK_WMASK 8'hFF
`define GROUP1_MASK_WMASK 8'h7F
`define GROUP2_MASK_WMASK 8'hFF

`define REG_RESET 8'h00

// Sense fields inside the sense-control register
`define SENSE0_LSB 0
`define SENSE1_LSB 2

// Request and vector-taken bit positions
`define VEC_LINE0 0
`define VEC_LINE1 1
`define VEC_GROUP0 2
`define VEC_GROUP1 3
`define VEC_GROUP2 4

// Edges after reset before line detectors trust their history
`define PRIME_EDGES 2

`endif

// file: design/ext_irq_pkg.sv
// Types shared by the external pin interrupt unit
package ext_irq_pkg;
   typedef enum logic [1:0] {
      SENSE_LOW = 2'h0,
      SENSE_ANY = 2'h1,
      SENSE_FALL = 2'h3,
      SENSE_RISE = 2'h2
   } sense_gray_type;
   typedef enum logic [1:0] {
      MODE_LOW = 2'h0,
      MODE_ANY = 2'h1,
      MODE_FALL = 2'h2,
      MODE_RISE = 2'h3
   } sense_type;
   typedef logic [4:0] vec_type;
endpackage: ext_irq_pkg

// file: design/line_sense_detect.sv
// Sense logic for one dedicated external interrupt line
`timescale 1ns/100ps
`include "ext_irq_defs.svh"
module line_sense_detect (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic pin_in,
   input wire ext_irq_pkg::sense_type sense_in,
   output logic event_out,
   output logic low_out
);
   import ext_irq_pkg::*;

   logic smp_r;
   logic prev_r;
   logic [1:0] primed_r;
   logic ev;

   // Sample first, then compare two samples
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         smp_r <= 1'b0;
         prev_r <= 1'b0;
         primed_r <= 2'h0;
      end else begin
         smp_r <= pin_in;
         prev_r <= smp_r;
         primed_r <= {primed_r[0], 1'b1};
      end
   end

   always_comb begin
      case (sense_in)
         MODE_ANY: ev = smp_r ^ prev_r;
         MODE_FALL: ev = prev_r & ~smp_r;
         MODE_RISE: ev = ~prev_r & smp_r;
         default: ev = 1'b0;
      endcase
   end

   // History is garbage until two samples exist
   assign event_out = ev & primed_r[1];
   // Level path bypasses the sampler so it needs no edge
   assign low_out = ~pin_in;
endmodule: line_sense_detect

// file: design/pin_change_group.sv
// Change detector for one group of masked pin-change inputs
`timescale 1ns/100ps
module pin_change_group #(
   parameter int WIDTH = 8
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic [WIDTH-1:0] pins_in,
   input wire logic [WIDTH-1:0] mask_in,
   input wire logic enable_in,
   output logic change_out
);
   logic [WIDTH-1:0] smp_r;
   logic primed_r;

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         smp_r <= '0;
         primed_r <= 1'b0;
      end else begin
         smp_r <= pins_in;
         primed_r <= 1'b1;
      end
   end

   // Live pins against last sample: change shows without waiting an edge
   assign change_out = enable_in & primed_r &
                       (|((pins_in ^ smp_r) & mask_in));
endmodule: pin_change_group

// file: tb/ext_pin_driver.sv
// Behavioural model of the circuitry driving the interrupt and change pins
`timescale 1ns/100ps
module ext_pin_driver (
   input wire logic clk_in,
   output logic line0_out,
   output logic line1_out,
   output logic [7:0] group0_out,
   output logic [6:0] group1_out,
   output logic [7:0] group2_out
);
   // Lines idle high, as if pulled up, so a low is always a real request
   initial begin
      line0_out = 1'b1;
      line1_out = 1'b1;
      group0_out = 8'h00;
      group1_out = 7'h00;
      group2_out = 8'h00;
   end

   // Callers keep each level for several clocks, never a sub-cycle glitch
   task automatic set_lines(input logic v);
      line0_out <= v;
      line1_out <= v;
   endtask: set_lines

   // A low level is held for n clocks before release
   task automatic hold_low(input int n);
      set_lines(1'b0);
      repeat (n) @(posedge clk_in);
      set_lines(1'b1);
   endtask: hold_low

   task automatic flip_group(input int g, input int b);
      case (g)
         0: group0_out[b] <= ~group0_out[b];
         1: group1_out[b] <= ~group1_out[b];
         default: group2_out[b] <= ~group2_out[b];
      endcase
   endtask: flip_group
endmodule: ext_pin_driver

// file: tb/testbench.sv
// Self-checking bench for the external pin interrupt unit
`timescale 1ns/100ps
`include "ext_irq_defs.svh"
module testbench;
   import ext_irq_pkg::*;
   typedef struct {
      logic [7:0] idx;
      logic [7:0] wd;
      logic [7:0] rd;
   } row_type;
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic hsel;
   logic hwrite;
   logic gie;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic hready;
   logic hresp;
   logic [1:0] exp;
   vec_type vtaken;
   vec_type req;
   logic line0;
   logic line1;
   logic [7:0] g0;
   logic [6:0] g1;
   logic [7:0] g2;
   int mismatches = 0;
   int n_checks = 0;
   // Written value beside what reads back; reserved bits and holes read 0
   row_type rows [7] = '{
      '{`SENSE_CTRL_IDX, 8'hFF, 8'h0F},
      '{`LINE_EN_IDX, 8'hFF, 8'h03},
      '{`GROUP_EN_IDX, 8'hFF, 8'h07},
      '{`GROUP0_MASK_IDX, 8'hFF, 8'hFF},
      '{`GROUP1_MASK_IDX, 8'hFF, 8'h7F},
      '{`GROUP2_MASK_IDX, 8'hA5, 8'hA5},
      '{8'h70, 8'hFF, 8'h00}};

   always #12.5 clk_in = ~clk_in;

   ext_pin_irq_unit i_ext_pin_irq_unit (
      .clk_in(clk_in), .rst_b_in(rst_b_in), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
      .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
      .global_irq_en_in(gie), .vector_taken_in(vtaken),
      .ext_line0_in(line0), .ext_line1_in(line1), .group0_pins_in(g0),
      .group1_pins_in(g1), .group2_pins_in(g2), .irq_request_out(req));

   ext_pin_driver i_ext_pin_driver (
      .clk_in(clk_in), .line0_out(line0), .line1_out(line1),
      .group0_out(g0), .group1_out(g1), .group2_out(g2));

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] want);
      n_checks++;
      if (seen !== want) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, want, seen);
      end
   endtask: check

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask: cyc

   // One single word transfer; entered and left just after a rising edge
   // Waits are open-ended; only the watchdog ends a stuck transfer
   task automatic bus(input logic w, input logic [7:0] idx,
                      input logic [7:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      haddr <= {2'h0, idx, 2'h0};
      do begin
         @(posedge clk_in);
      end while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, wd};
      do begin
         @(posedge clk_in);
      end while (hready !== 1'b1);
      rd = hrdata;
   endtask: bus

   task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
      bus(1'b1, idx, wd);
   endtask: wr

   task automatic rdc(input string what, input logic [7:0] idx,
                      input logic [7:0] want);
      bus(1'b0, idx, 8'h00);
      check(what, rd, {24'h00_0000, want});
   endtask: rdc

   task automatic chkreq(input string what, input vec_type want);
      check(what, {27'h000_0000, req}, {27'h000_0000, want});
   endtask: chkreq

   task automatic pulse_taken(input vec_type v);
      vtaken <= v;
      cyc(1);
      vtaken <= 5'h00;
      cyc(1);
   endtask: pulse_taken

   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask: tally_and_finish

   // Whole run is a few hundred cycles; this margin only catches a hang
   initial begin
      cyc(5000);
      mismatches++;
      tally_and_finish();
   end

   initial begin
      hsel <= 1'b0;
      hwrite <= 1'b0;
      gie <= 1'b0;
      haddr <= 12'h000;
      htrans <= 2'h0;
      hsize <= 3'h0;
      hwdata <= 32'h0000_0000;
      vtaken <= 5'h00;
      cyc(3);
      rst_b_in <= 1'b1;
      foreach (rows[i]) begin
         wr(rows[i].idx, rows[i].wd);
         rdc("reg", rows[i].idx, rows[i].rd);
      end
      // Edge sensing: each mode sees a fall, then a rise, on both lines
      gie <= 1'b1;
      for (int m = 1; m < 4; m++) begin
         wr(`SENSE_CTRL_IDX, 8'(m * 5));
         wr(`LINE_FLAG_IDX, 8'h03);
         i_ext_pin_driver.set_lines(1'b0);
         cyc(5);
         exp = (m != 3) ? 2'h3 : 2'h0;
         chkreq("fall req", {3'h0, exp});
         rdc("fall flag", `LINE_FLAG_IDX, {6'h00, exp});
         wr(`LINE_FLAG_IDX, 8'h03);
         i_ext_pin_driver.set_lines(1'b1);
         cyc(5);
         exp = (m != 2) ? 2'h3 : 2'h0;
         chkreq("rise req", {3'h0, exp});
         rdc("rise flag", `LINE_FLAG_IDX, {6'h00, exp});
      end
      // Write zero keeps flags, a taken vector clears only its own line
      wr(`SENSE_CTRL_IDX, 8'h0A);
      wr(`LINE_FLAG_IDX, 8'h03);
      i_ext_pin_driver.set_lines(1'b0);
      cyc(5);
      wr(`LINE_FLAG_IDX, 8'h00);
      rdc("w0 flag", `LINE_FLAG_IDX, 8'h03);
      pulse_taken(5'h01);
      chkreq("taken req", 5'h02);
      rdc("taken flag", `LINE_FLAG_IDX, 8'h02);
      gie <= 1'b0;
      cyc(2);
      chkreq("gie off", 5'h00);
      gie <= 1'b1;
      wr(`LINE_EN_IDX, 8'h01);
      cyc(2);
      chkreq("en1 off", 5'h00);
      // Low level requests while held, flags stay clear
      wr(`LINE_EN_IDX, 8'h03);
      wr(`SENSE_CTRL_IDX, 8'h00);
      i_ext_pin_driver.set_lines(1'b1);
      cyc(3);
      fork
         i_ext_pin_driver.hold_low(6);
      join_none
      cyc(3);
      chkreq("level req", 5'h03);
      rdc("level flag", `LINE_FLAG_IDX, 8'h00);
      cyc(4);
      chkreq("level gone", 5'h00);
      i_ext_pin_driver.set_lines(1'b0);
      cyc(3);
      gie <= 1'b0;
      cyc(2);
      chkreq("level gie", 5'h00);
      i_ext_pin_driver.set_lines(1'b1);
      gie <= 1'b1;
      // Pin-change groups: masked pin ignored, one pin per group fires
      wr(`GROUP0_MASK_IDX, 8'h01);
      wr(`GROUP1_MASK_IDX, 8'h40);
      wr(`GROUP2_MASK_IDX, 8'h80);
      wr(`GROUP_EN_IDX, 8'h07);
      wr(`GROUP_FLAG_IDX, 8'h07);
      i_ext_pin_driver.flip_group(0, 1);
      cyc(3);
      rdc("masked pin", `GROUP_FLAG_IDX, 8'h00);
      i_ext_pin_driver.flip_group(0, 0);
      i_ext_pin_driver.flip_group(1, 6);
      i_ext_pin_driver.flip_group(2, 7);
      cyc(3);
      chkreq("group req", 5'h1C);
      rdc("group flag", `GROUP_FLAG_IDX, 8'h07);
      pulse_taken(5'h08);
      chkreq("group taken", 5'h14);
      wr(`GROUP_FLAG_IDX, 8'h04);
      rdc("group w1c", `GROUP_FLAG_IDX, 8'h01);
      wr(`GROUP_EN_IDX, 8'h00);
      wr(`GROUP_FLAG_IDX, 8'h07);
      i_ext_pin_driver.flip_group(0, 0);
      cyc(3);
      rdc("group off", `GROUP_FLAG_IDX, 8'h00);
      chkreq("group off", 5'h00);
      // Reset in mid-run with a group flag pending
      wr(`GROUP_EN_IDX, 8'h07);
      i_ext_pin_driver.flip_group(1, 6);
      cyc(3);
      rst_b_in <= 1'b0;
      cyc(3);
      rst_b_in <= 1'b1;
      chkreq("reset req", 5'h00);
      foreach (rows[i]) begin
         rdc("reset reg", rows[i].idx, 8'h00);
      end
      rdc("reset lflag", `LINE_FLAG_IDX, 8'h00);
      rdc("reset gflag", `GROUP_FLAG_IDX, 8'h00);
      check("resp", {31'h0000_0000, hresp}, 32'h0000_0000);
      check("ready", {31'h0000_0000, hready}, 32'h0000_0001);
      tally_and_finish();
   end
endmodule: testbench
